// >>> verilog/lfwd_top.sv
// Slow-clock 16-bit watchdog: counter, match interrupt, third-event reset.
// Assumes slow_osc_clk and deep_sleep_wake are asynchronous pins, and
// sleep_mode comes from power logic on core_clk.
//
// Function
// - Sixteen-bit up-counter advances on every slow tick while enabled.
// - Counter equal to match value raises the watchdog interrupt.
// - Match never clears the counter; it wraps and matches again.
// - Ignore-bits field removes that many top bits from the counter.
// - Reset follows two full periods plus match from a cleared counter.
// - Interrupt goes to CPU line 4 when active, wake controller when asleep.
// - Enable or disable takes three slow cycles; keep system clock meanwhile.
// - After deep-sleep wake, count reads zero until next oscillator edge.
// - Counter runs only from the internal slow oscillator ticks.
// - Oscillator disable writes are ignored while watchdog reset is enabled.
// - Enabling watchdog reset switches the slow oscillator on.
// - Writes take effect after three slow cycles; clear four before timeout.
// - Clearing the pending interrupt zeroes the unhandled-event counter, or sets it to one on a match in the same tick.
// - Interrupt stays pending until software clears it at the block.
// - CPU path stays masked until software sets the unmask control.
// - Third unhandled interrupt asserts device reset, held while it persists.
// - Watchdog-caused reset is recorded for software to read later.
// - No register write-lock exists in this watchdog.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module lfwd_top
    import lfwd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        slow_osc_clk,
    input  wire logic        deep_sleep_wake,
    input  wire logic        sleep_mode,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    output logic             irq_cpu,
    output logic             irq_wakeup,
    output logic             wdt_reset,
    output logic             osc_enable
);

    // -------------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------------
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    logic        wake_s1;
    logic        wake_s2;
    logic        wake_s3;
    logic        tick;
    logic        wake_edge;
    lfwd_cfg_t   cfg_sw;
    lfwd_cfg_t   cfg_pipe [3];
    lfwd_cfg_t   cfg_eff;
    logic [15:0] count;
    logic [15:0] mask;
    logic        hit;
    logic        irq_pend;
    logic [1:0]  evt_cnt;
    logic        reset_cause;
    logic        view_zero;
    logic [1:0]  req_set;
    logic [1:0]  pend;
    logic [1:0]  apply;
    logic        wr_ctrl;
    logic        wr_cmd;

    // -------------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------------
    // Third stage only for edge detection; first stage feeds nothing else
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            osc_s1  <= 1'b0;
            osc_s2  <= 1'b0;
            osc_s3  <= 1'b0;
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            wake_s3 <= 1'b0;
        end
        else
        begin
            osc_s1  <= slow_osc_clk;
            osc_s2  <= osc_s1;
            osc_s3  <= osc_s2;
            wake_s1 <= deep_sleep_wake;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
        end
    end

    // Slow rate as a one-cycle enable; the oscillator is the only time base
    assign tick      = osc_s2 & ~osc_s3;
    assign wake_edge = wake_s2 & ~wake_s3;

    // -------------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------------
    // No lock bit: every write is accepted at any time, except an oscillator disable while reset is enabled
    assign wr_ctrl = wr_en && (addr == `LFWD_CTRL_ADDR);
    assign wr_cmd  = wr_en && (addr == `LFWD_CMD_ADDR);

    // Software-side configuration
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_sw <= '{match: `LFWD_MATCH_RST, ignore: 4'h0, unmask: 1'b0,
                        reset_en: 1'b0, enable: 1'b0};
        end
        else
        begin
            if (wr_ctrl)
            begin
                cfg_sw.enable   <= wdata[`LFWD_CTRL_EN];
                cfg_sw.reset_en <= wdata[`LFWD_CTRL_RSTEN];
                cfg_sw.unmask   <= wdata[`LFWD_CTRL_UNMASK];
                cfg_sw.ignore   <= wdata[`LFWD_CTRL_IGN_HI:`LFWD_CTRL_IGN_LO];
            end
            if (wr_en && (addr == `LFWD_MATCH_ADDR))
            begin
                cfg_sw.match <= wdata[15:0];
            end
        end
    end

    // Oscillator enable: a disable only lands once reset is already off
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            osc_enable <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            osc_enable <= wdata[`LFWD_CTRL_OSC]
                        | wdata[`LFWD_CTRL_RSTEN]
                        | cfg_sw.reset_en;
        end
    end

    // -------------------------------------------------------------------------
    // Apply stages: config reaches the counter after three slow ticks
    // -------------------------------------------------------------------------
    // Costs latency but keeps a half-written word away from the counter
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 3; i++)
            begin
                cfg_pipe[i] <= '{match: `LFWD_MATCH_RST, ignore: 4'h0, unmask: 1'b0,
                                 reset_en: 1'b0, enable: 1'b0};
            end
        end
        else if (tick)
        begin
            cfg_pipe[0] <= cfg_sw;
            cfg_pipe[1] <= cfg_pipe[0];
            cfg_pipe[2] <= cfg_pipe[1];
        end
    end

    assign cfg_eff = cfg_pipe[2];

    // -------------------------------------------------------------------------
    // Clear requests: held until taken on a slow tick
    // -------------------------------------------------------------------------
    assign req_set[0] = wr_cmd && wdata[`LFWD_CMD_CLRCNT];
    assign req_set[1] = (wr_cmd && wdata[`LFWD_CMD_CLRIRQ])
                     || (wr_en && (addr == `LFWD_STATUS_ADDR) && wdata[`LFWD_STAT_IRQ]);

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_req
            logic [1:0] age;
            logic       held;

            // Request stays up until the third tick consumes it
            always_ff @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    held <= 1'b0;
                    age  <= 2'h0;
                end
                else if (req_set[g] && !held)
                begin
                    held <= 1'b1;
                    age  <= 2'h0;
                end
                else if (held && tick)
                begin
                    age  <= age + 2'h1;
                    held <= (age + 2'h1) != `LFWD_APPLY_TICKS;
                end
            end

            // One process per bit owns its flag; the vector only gathers them
            assign pend[g]  = held;
            assign apply[g] = held && tick && ((age + 2'h1) == `LFWD_APPLY_TICKS);
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Counter
    // -------------------------------------------------------------------------
    assign mask = 16'hFFFF >> cfg_eff.ignore;
    assign hit  = tick && cfg_eff.enable
               && ((count & mask) == (cfg_eff.match & mask));

    // Match leaves the counter alone; only a clear request zeroes it
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= 16'h0000;
        end
        else if (apply[0])
        begin
            count <= 16'h0000;
        end
        else if (tick && cfg_eff.enable)
        begin
            count <= (count + 16'h0001) & mask;
        end
    end

    // -------------------------------------------------------------------------
    // Pending interrupt and unhandled-event count
    // -------------------------------------------------------------------------
    // A match in the clearing tick wins, so no event is lost
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_pend <= 1'b0;
            evt_cnt  <= 2'h0;
        end
        else
        begin
            if (hit)
            begin
                irq_pend <= 1'b1;
            end
            else if (apply[1])
            begin
                irq_pend <= 1'b0;
            end
            if (apply[1])
            begin
                evt_cnt <= hit ? 2'h1 : 2'h0;
            end
            else if (hit && (evt_cnt != `LFWD_RESET_EVENTS))
            begin
                evt_cnt <= evt_cnt + 2'h1;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Reset request and cause
    // -------------------------------------------------------------------------
    // Held for as long as the third event stays uncleared
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wdt_reset <= 1'b0;
        end
        else
        begin
            wdt_reset <= cfg_eff.reset_en && (evt_cnt == `LFWD_RESET_EVENTS);
        end
    end

    // Cleared only by power-on reset or a write of one; set wins
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reset_cause <= 1'b0;
        end
        else if (wdt_reset)
        begin
            reset_cause <= 1'b1;
        end
        else if (wr_en && (addr == `LFWD_STATUS_ADDR) && wdata[`LFWD_STAT_CAUSE])
        begin
            reset_cause <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Interrupt routing
    // -------------------------------------------------------------------------
    // Masked until unmasked; asleep, the request goes to the wake controller
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_cpu    <= 1'b0;
            irq_wakeup <= 1'b0;
        end
        else
        begin
            irq_cpu    <= irq_pend && cfg_eff.unmask && !sleep_mode;
            irq_wakeup <= irq_pend && cfg_eff.unmask && sleep_mode;
        end
    end

    // -------------------------------------------------------------------------
    // Wake hold and read-back
    // -------------------------------------------------------------------------
    // Count view stays zero from a wake until the oscillator edge reloads it
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            view_zero <= 1'b0;
        end
        else if (tick)
        begin
            view_zero <= 1'b0;
        end
        else if (wake_edge)
        begin
            view_zero <= 1'b1;
        end
    end

    // Unmapped offsets read as zero
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            unique case (addr)
                `LFWD_CTRL_ADDR:   rdata <= {24'h000000, cfg_sw.ignore, osc_enable,
                                             cfg_sw.unmask, cfg_sw.reset_en, cfg_sw.enable};
                `LFWD_MATCH_ADDR:  rdata <= {16'h0000, cfg_sw.match};
                `LFWD_COUNT_ADDR:  rdata <= view_zero ? 32'h0000_0000 : {16'h0000, count};
                `LFWD_STATUS_ADDR: rdata <= {26'h0000000, view_zero, osc_enable,
                                             reset_cause, evt_cnt, irq_pend};
                default:           rdata <= 32'h0000_0000;
            endcase
        end
        else
        begin
            rdata <= 32'h0000_0000;
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    logic [1:0] cfg_age;

    // Ticks since software config last changed, saturating
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_age <= 2'h0;
        end
        else if (cfg_sw != cfg_pipe[0] && tick)
        begin
            cfg_age <= 2'h1;
        end
        else if (tick && cfg_age != `LFWD_APPLY_TICKS)
        begin
            cfg_age <= cfg_age + 2'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_count_step: assert property (tick && cfg_eff.enable && !apply[0] && count != mask
        |=> count == $past(count) + 16'h0001) else $error("count did not step");
    a_count_wrap: assert property (tick && cfg_eff.enable && !apply[0] && count == mask
        |=> count == 16'h0000) else $error("count did not wrap");
    a_match_irq: assert property (hit |=> irq_pend ##1 irq_cpu || irq_wakeup || !cfg_eff.unmask)
        else $error("match lost");
    a_irq_sticky: assert property (irq_pend && !apply[1] |=> irq_pend)
        else $error("pending dropped");
    a_clr_events: assert property (apply[1] && !hit |=> evt_cnt == 2'h0 && !irq_pend)
        else $error("clear missed events");
    a_third_reset: assert property (cfg_eff.reset_en && evt_cnt == 2'h3 |=> wdt_reset)
        else $error("no reset on third event");
    a_cause_kept: assert property (wdt_reset |=> reset_cause)
        else $error("cause not recorded");
    a_osc_locked: assert property (cfg_sw.reset_en |-> osc_enable)
        else $error("osc off with reset on");
    a_osc_start: assert property (wr_ctrl && wdata[`LFWD_CTRL_RSTEN] |=> osc_enable)
        else $error("osc not started");
    a_cpu_masked: assert property (!cfg_eff.unmask |=> !irq_cpu && !irq_wakeup)
        else $error("masked irq leaked");
    a_route_one: assert property (!(irq_cpu && irq_wakeup))
        else $error("irq on both paths");
    a_apply_late: assert property (cfg_age == 2'h3 && !tick |-> cfg_eff == cfg_sw || cfg_sw != cfg_pipe[0])
        else $error("config not applied");
    a_wake_zero: assert property (view_zero && rd_en && addr == `LFWD_COUNT_ADDR |=> rdata == 32'h0)
        else $error("count visible after wake");

    c_match: cover property (hit ##[1:50] apply[1]);
    c_reset: cover property ($rose(wdt_reset));
    c_wake_read: cover property (view_zero && rd_en && addr == `LFWD_COUNT_ADDR);
    c_cnt_clear: cover property (apply[0] && count != 16'h0000);

endmodule

`default_nettype wire

// >>> verilog/lfwd_regs.svh
// Register map, field positions and timing counts of the slow-clock watchdog.
// Assumes inclusion from the package and the testbench only.
`ifndef LFWD_REGS_SVH
`define LFWD_REGS_SVH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define LFWD_CTRL_ADDR     8'h00
`define LFWD_MATCH_ADDR    8'h04
`define LFWD_COUNT_ADDR    8'h08
`define LFWD_STATUS_ADDR   8'h0C
`define LFWD_CMD_ADDR      8'h10

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define LFWD_CTRL_EN       0
`define LFWD_CTRL_RSTEN    1
`define LFWD_CTRL_UNMASK   2
`define LFWD_CTRL_OSC      3
`define LFWD_CTRL_IGN_LO   4
`define LFWD_CTRL_IGN_HI   7
`define LFWD_STAT_IRQ      0
`define LFWD_STAT_EVT_LO   1
`define LFWD_STAT_EVT_HI   2
`define LFWD_STAT_CAUSE    3
`define LFWD_STAT_OSC      4
`define LFWD_STAT_HOLD     5
`define LFWD_CMD_CLRCNT    0
`define LFWD_CMD_CLRIRQ    1

// -----------------------------------------------------------------------------
// Reset values and timing counts
// -----------------------------------------------------------------------------
`define LFWD_MATCH_RST     16'hFFFF
`define LFWD_APPLY_TICKS   2'h3
`define LFWD_RESET_EVENTS  2'h3

`endif

// >>> verilog/lfwd_pkg.sv
// Types shared by the slow-clock watchdog.
// Assumes the register header sits beside it.
`include "lfwd_regs.svh"

package lfwd_pkg;

    // Configuration that travels through the slow-tick apply stages
    typedef struct packed {
        logic [15:0] match;
        logic [3:0]  ignore;
        logic        unmask;
        logic        reset_en;
        logic        enable;
    } lfwd_cfg_t;

endpackage

// >>> verif/lfwd_osc_model.sv
// Far side: slow oscillator and reset-request monitor.
// Assumes the bench pauses the oscillator only to model deep sleep.
`timescale 1ns/10ps
`default_nettype none

module lfwd_osc_model
#(
    parameter int HALF_NS = 80
)
(
    input  wire logic osc_enable,
    input  wire logic pause,
    input  wire logic wdt_reset,
    output logic      slow_clk,
    output var int    resets_seen
);
    // Oscillator runs only while enabled; idles low, so no stray tick
    initial slow_clk = 1'b0;
    always
    begin
        if (osc_enable && !pause)
        begin
            #(HALF_NS) slow_clk = ~slow_clk;
        end
        else
        begin
            slow_clk = 1'b0;
            @(osc_enable or pause);
        end
    end

    // Reset logic tallies each new request
    initial resets_seen = 0;
    always @(posedge wdt_reset) resets_seen++;
endmodule

`default_nettype wire

// >>> verif/lfclk_watchdog_16bit_test.sv
// Self-checking bench for the slow-clock watchdog.
// Assumes the oscillator model drives the slow clock pin.
`timescale 1ns/10ps
`default_nettype none
`include "lfwd_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %0h, expected %0h", $time, (g), (e)); end end

module lfclk_watchdog_16bit_test
    import lfwd_pkg::*;
;
    logic        core_clk, nrst, slow_osc_clk, deep_sleep_wake, sleep_mode, pause;
    logic        wr_en, rd_en, irq_cpu, irq_wakeup, wdt_reset, osc_enable;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, d, c;
    int          failures, tests_run, edges, e0, resets_seen;

    // ----------------
    // Design and far side
    // ----------------
    lfwd_top dut (
        .core_clk        (core_clk),
        .nrst            (nrst),
        .slow_osc_clk    (slow_osc_clk),
        .deep_sleep_wake (deep_sleep_wake),
        .sleep_mode      (sleep_mode),
        .addr            (addr),
        .wdata           (wdata),
        .wr_en           (wr_en),
        .rd_en           (rd_en),
        .rdata           (rdata),
        .irq_cpu         (irq_cpu),
        .irq_wakeup      (irq_wakeup),
        .wdt_reset       (wdt_reset),
        .osc_enable      (osc_enable)
    );
    lfwd_osc_model #(.HALF_NS(80)) osc (
        .osc_enable  (osc_enable),
        .pause       (pause),
        .wdt_reset   (wdt_reset),
        .slow_clk    (slow_osc_clk),
        .resets_seen (resets_seen)
    );

    // Core clock and slow edge tally
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge slow_osc_clk) edges++;

    // ----------------
    // Access tasks
    // ----------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand one cycle only, so sample mid-cycle
    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        @(negedge core_clk);
        d = rdata;
        `CHK(d & m, e);
    endtask

    function automatic logic pick(input int s);
        return s ? wdt_reset : irq_cpu;
    endfunction

    // Bounded wait; running out shows as a mismatch
    task automatic wait_sig(input int s, input logic v);
        int n;
        n = 0;
        while (pick(s) !== v && n < 2000)
        begin
            @(negedge core_clk);
            n++;
        end
        `CHK(pick(s), v);
    endtask

    // Slow ticks plus synchroniser slack
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge slow_osc_clk);
        repeat (6) @(negedge core_clk);
    endtask

    task automatic results();
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard: expected run is a few thousand cycles
    initial
    begin
        #300000;
        failures++;
        results();
    end

    // ----------------
    // Test sequence
    // ----------------
    initial
    begin
        nrst            = 1'b0;
        addr            = 8'h00;
        wdata           = 32'h0;
        wr_en           = 1'b0;
        rd_en           = 1'b0;
        sleep_mode      = 1'b0;
        deep_sleep_wake = 1'b0;
        pause           = 1'b0;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        // Reset state, unmapped place, no write lock
        `CHK({irq_cpu, irq_wakeup, wdt_reset, osc_enable}, 4'h0);
        chk(`LFWD_MATCH_ADDR, 32'hFFFF, 32'hFFFF);
        chk(`LFWD_STATUS_ADDR, 32'h3F, 32'h0);
        wr(8'h3C, 32'hFFFFFFFF);
        chk(8'h3C, 32'hFFFFFFFF, 32'h0);
        chk(`LFWD_CTRL_ADDR, 32'hFF, 32'h0);
        wr(`LFWD_MATCH_ADDR, 32'h1234);
        chk(`LFWD_MATCH_ADDR, 32'hFFFF, 32'h1234);
        // Oscillator interlock with reset enable
        wr(`LFWD_CTRL_ADDR, 32'h02);
        chk(`LFWD_STATUS_ADDR, 32'h10, 32'h10);
        wait_ticks(4);
        wr(`LFWD_CTRL_ADDR, 32'h00);
        wait_ticks(1);
        `CHK(osc_enable, 1'b1);
        chk(`LFWD_CTRL_ADDR, 32'h0A, 32'h08);
        wr(`LFWD_CTRL_ADDR, 32'h08);
        // Match with 12 ignored bits: 4-bit counter
        wr(`LFWD_MATCH_ADDR, 32'h5);
        wr(`LFWD_CTRL_ADDR, 32'hCD);
        wr(`LFWD_CMD_ADDR, 32'h3);
        wait_sig(0, 1'b1);
        e0 = edges;
        chk(`LFWD_COUNT_ADDR, 32'hFFFF, 32'h6);
        `CHK(irq_wakeup, 1'b0);
        repeat (40) @(negedge core_clk);
        `CHK(irq_cpu, 1'b1);
        wr(`LFWD_CMD_ADDR, 32'h2);
        wait_sig(0, 1'b0);
        wait_sig(0, 1'b1);
        `CHK(edges - e0, 32'h10);
        // Service code moves the match on by eight
        e0 = edges;
        wr(`LFWD_MATCH_ADDR, 32'hD);
        wr(`LFWD_STATUS_ADDR, 32'h1);
        wait_sig(0, 1'b0);
        wait_sig(0, 1'b1);
        `CHK(edges - e0, 32'h8);
        // Sleep routes the request to the wake controller
        @(posedge core_clk);
        sleep_mode <= 1'b1;
        repeat (3) @(negedge core_clk);
        `CHK({irq_cpu, irq_wakeup}, 2'b01);
        @(posedge core_clk);
        sleep_mode <= 1'b0;
        // Mask holds the request back
        wr(`LFWD_CTRL_ADDR, 32'hC9);
        wait_sig(0, 1'b0);
        chk(`LFWD_STATUS_ADDR, 32'h1, 32'h1);
        wr(`LFWD_CTRL_ADDR, 32'hCD);
        wait_sig(0, 1'b1);
        // Disable freezes the count after three ticks
        wr(`LFWD_CTRL_ADDR, 32'hC8);
        wait_ticks(4);
        chk(`LFWD_COUNT_ADDR, 32'hFFFF0000, 32'h0);
        c = d;
        wait_ticks(4);
        chk(`LFWD_COUNT_ADDR, 32'hFFFF, c);
        // Deep-sleep wake with oscillator stalled
        @(posedge core_clk);
        pause <= 1'b1;
        repeat (12) @(negedge core_clk);
        deep_sleep_wake <= 1'b1;
        repeat (10) @(negedge core_clk);
        chk(`LFWD_COUNT_ADDR, 32'hFFFF, 32'h0);
        chk(`LFWD_STATUS_ADDR, 32'h20, 32'h20);
        @(posedge core_clk);
        pause <= 1'b0;
        wait_ticks(1);
        chk(`LFWD_STATUS_ADDR, 32'h20, 32'h0);
        chk(`LFWD_COUNT_ADDR, 32'hFFFF, c);
        deep_sleep_wake <= 1'b0;
        // Third unhandled hit resets the device
        wr(`LFWD_MATCH_ADDR, 32'h3);
        wr(`LFWD_CMD_ADDR, 32'h2);
        wait_sig(0, 1'b0);
        wr(`LFWD_CTRL_ADDR, 32'hCF);
        wait_sig(0, 1'b1);
        e0 = edges;
        wait_sig(1, 1'b1);
        `CHK(edges - e0, 32'h20);
        repeat (100) @(negedge core_clk);
        `CHK(wdt_reset, 1'b1);
        chk(`LFWD_STATUS_ADDR, 32'h1F, 32'h1F);
        wr(`LFWD_CMD_ADDR, 32'h2);
        wait_sig(1, 1'b0);
        chk(`LFWD_STATUS_ADDR, 32'h0F, 32'h08);
        wr(`LFWD_STATUS_ADDR, 32'h08);
        chk(`LFWD_STATUS_ADDR, 32'h08, 32'h0);
        wr(`LFWD_CTRL_ADDR, 32'h08);
        `CHK(resets_seen, 1);
        results();
    end
endmodule

`default_nettype wire
